// ==== design/usbebc_core.sv ====
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps

// Overview of operation
// RL1 - Download mode: hardware finishes endpoint 2 OUT, no event, revalidates.
// RL2 - In download mode endpoint 2 IN stays software managed with events.
// RL3 - Short packet in download: back to normal, event, reception NAK.
// RL4 - Upload mode: hardware handles endpoint 2 IN like download OUT.
// RL5 - Reception ok flag set by hardware, cleared by software.
// RL6 - Reception toggle flips only on correct packet with matching PID.
// RL7 - Reception status: 00 off, 01 stall, 10 NAK, 11 valid.
// RL8 - Reception status forced to NAK after a correct transfer.
// RL9 - Reception status writes ignored while in download mode.
// RL10 - Transmission status writes ignored while in upload mode.
// RL11 - Bus reset or forced reset clears low three transmission bits; the code also clears the transmission ok flag, bit 3.
// RL12 - Transmission ok flag set by hardware, cleared by software.
// RL13 - Transmission toggle flips on ACK; software may also write toggles.
// RL14 - Transmission status: 00 off, 01 stall, 10 NAK, 11 valid.
// RL15 - Transmission status forced to NAK after a correct transfer.
// RL16 - Endpoint 0/1 reception counters decremented by received bytes.
// RL17 - Endpoint 2 reception counter decremented by received bytes.
// RL18 - Endpoint 0/1 transmission counters give bytes sent at next IN.
// RL19 - Reception control bits five and four always read zero.
// RL20 - Mode field: 00 normal, 01 upload, 10 download.
// RL21 - Endpoint 2 transmission counter gives bytes sent at next IN.
// RL22 - Leaving download after short packet also clears mode to normal.
module usbebc_core
	import usbebc_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic USB_RST_I,
	input wire logic EP2_TOKEN_I,
	input wire logic EP2_TOKEN_IN_I,
	output logic EP2_ACCEPT_O,
	output logic EP2_STALL_O,
	output logic EP2_NAK_O,
	input wire logic XACT_DONE_I,
	input wire logic [1:0] XACT_EP_I,
	input wire logic XACT_IN_I,
	input wire logic XACT_PID_I,
	input wire logic [usbebc_pkg::LEN_W-1:0] XACT_LEN_I,
	input wire logic BUF_READY_I,
	output logic TRANSFER_OK_EVENT_O,
	output logic COPROC_PKT_O,
	output logic [usbebc_pkg::CNT01_W-1:0] EP0_TX_BYTE_COUNT_O,
	output logic [usbebc_pkg::CNT01_W-1:0] EP1_TX_BYTE_COUNT_O,
	output logic [usbebc_pkg::CNT2_W-1:0] EP2_TX_BYTE_COUNT_O,
	output logic [usbebc_pkg::CNT01_W-1:0] EP0_RX_BYTE_COUNT_O,
	output logic [usbebc_pkg::CNT01_W-1:0] EP1_RX_BYTE_COUNT_O,
	output logic [usbebc_pkg::CNT2_W-1:0] EP2_RX_BYTE_COUNT_O,
	output logic EP2_RX_PID_TOGGLE_O,
	output logic EP2_TX_PID_TOGGLE_O,
	output logic [1:0] EP2_TRANSFER_MODE_O,
	output logic FORCE_BUS_RESET_O
);
	import usbebc_pkg::*;

	// ***************************************************************
	// wishbone slave decode
	// ***************************************************************
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic [5:0] idx;
	logic bus_req;
	logic wr;
	logic [7:0] wd;
	logic wr_ctrl;
	logic wr_ep0_rx;
	logic wr_ep0_tx;
	logic wr_ep1_rx;
	logic wr_ep1_tx;
	logic wr_ep2_rx;
	logic wr_ep2_rxc;
	logic wr_ep2_tx;
	logic wr_ep2_txc;

	assign idx = ADR_I[7:2];
	assign bus_req = CYC_I && STB_I && !ack_reg;
	// only the low byte lane holds register bits
	assign wr = bus_req && WE_I && SEL_I[0];
	assign wd = DAT_I[7:0];
	assign wr_ctrl = wr && (idx == IDX_CTRL);
	assign wr_ep0_rx = wr && (idx == IDX_EP0_RX_CNT);
	assign wr_ep0_tx = wr && (idx == IDX_EP0_TX_CNT);
	assign wr_ep1_rx = wr && (idx == IDX_EP1_RX_CNT);
	assign wr_ep1_tx = wr && (idx == IDX_EP1_TX_CNT);
	assign wr_ep2_rx = wr && (idx == IDX_EP2_RX_CTRL);
	assign wr_ep2_rxc = wr && (idx == IDX_EP2_RX_CNT);
	assign wr_ep2_tx = wr && (idx == IDX_EP2_TX_CTRL);
	assign wr_ep2_txc = wr && (idx == IDX_EP2_TX_CNT);

	// ***************************************************************
	// state registers
	// ***************************************************************
	logic force_bus_reset_reg;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic rx_ctr_reg;
	logic rx_ctr_next;
	logic rx_tog_reg;
	logic rx_tog_next;
	logic [1:0] rx_stat_reg;
	logic [1:0] rx_stat_next;
	logic tx_ctr_reg;
	logic tx_ctr_next;
	logic tx_tog_reg;
	logic tx_tog_next;
	logic [1:0] tx_stat_reg;
	logic [1:0] tx_stat_next;
	logic [CNT01_W-1:0] ep0_tx_reg;
	logic [CNT01_W-1:0] ep1_tx_reg;
	logic [CNT2_W-1:0] ep2_tx_reg;
	logic [CNT2_W-1:0] rx_max_reg;
	logic [CNT2_W-1:0] tx_max_reg;
	logic rx_wait_reg;
	logic rx_wait_next;
	logic tx_wait_reg;
	logic tx_wait_next;
	logic evt_reg;
	logic evt_next;
	logic hw_pkt_reg;
	logic hw_pkt_next;

	// ***************************************************************
	// transaction classification
	// ***************************************************************
	logic bus_reset;
	logic ep2_out;
	logic ep2_in;
	logic dl_mode;
	logic ul_mode;
	logic rx_short;
	logic tx_short;
	logic rx_hw;
	logic tx_hw;
	logic rx_sw;
	logic tx_sw;
	logic rx_revalid;
	logic tx_revalid;
	logic ep0_dec;
	logic ep1_dec;
	logic [CNT01_W-1:0] ep0_rx_cnt;
	logic [CNT01_W-1:0] ep1_rx_cnt;
	logic [CNT2_W-1:0] ep2_rx_cnt;

	// RL11 reset sources
	assign bus_reset = USB_RST_I || force_bus_reset_reg;
	assign ep2_out = XACT_DONE_I && (XACT_EP_I == 2'h2) && !XACT_IN_I;
	assign ep2_in = XACT_DONE_I && (XACT_EP_I == 2'h2) && XACT_IN_I;
	// RL20 mode decode
	assign dl_mode = (mode_reg == MODE_DOWNLOAD);
	assign ul_mode = (mode_reg == MODE_UPLOAD);
	// RL3 short packet against programmed maximum
	assign rx_short = CNT2_W'(XACT_LEN_I) < rx_max_reg;
	assign tx_short = CNT2_W'(XACT_LEN_I) < tx_max_reg;
	// RL1 full packets absorbed by hardware in download mode
	assign rx_hw = ep2_out && dl_mode && !rx_short;
	// RL4 full packets absorbed by hardware in upload mode
	assign tx_hw = ep2_in && ul_mode && !tx_short;
	// RL2 everything else ends with a software event
	assign rx_sw = ep2_out && !rx_hw;
	assign tx_sw = ep2_in && !tx_hw;
	assign rx_revalid = rx_wait_reg && BUF_READY_I && dl_mode;
	assign tx_revalid = tx_wait_reg && BUF_READY_I && ul_mode;
	assign ep0_dec = XACT_DONE_I && (XACT_EP_I == 2'h0) && !XACT_IN_I;
	assign ep1_dec = XACT_DONE_I && (XACT_EP_I == 2'h1) && !XACT_IN_I;

	// ***************************************************************
	// endpoint 2 reception control
	// ***************************************************************
	always_comb
	begin
		mode_next = mode_reg;
		if (wr_ep2_rx)
			mode_next = wd[BIT_MODE_HI:BIT_MODE_LO];
		// RL22 short packet drops download mode
		if (ep2_out && dl_mode && rx_short)
			mode_next = MODE_NORMAL;
		// upload ends the same way on a short IN
		if (ep2_in && ul_mode && tx_short)
			mode_next = MODE_NORMAL;
	end

	always_comb
	begin
		rx_ctr_next = rx_ctr_reg;
		rx_tog_next = rx_tog_reg;
		rx_stat_next = rx_stat_reg;
		// RL5 software clears by writing zero, set wins below
		if (wr_ep2_rx)
			rx_ctr_next = rx_ctr_reg && wd[BIT_CTR];
		// RL13 software may force the toggle
		if (wr_ep2_rx)
			rx_tog_next = wd[BIT_TOG];
		// RL9 protected in download mode
		if (wr_ep2_rx && !dl_mode)
			rx_stat_next = wd[BIT_STAT_HI:BIT_STAT_LO];
		// RL6 flip on matching PID
		if (ep2_out && (XACT_PID_I == rx_tog_reg))
			rx_tog_next = !rx_tog_reg;
		// RL5 hardware set
		if (rx_sw)
			rx_ctr_next = 1'b1;
		// RL8 hold off until software has looked
		if (ep2_out)
			rx_stat_next = STAT_NAK;
		// RL1 revalidate once the buffer accepts more
		if (rx_revalid)
			rx_stat_next = STAT_VALID;
		// RL11 bus reset clears bits 2:0
		if (bus_reset)
		begin
			rx_tog_next = RST_BIT;
			rx_stat_next = RST_STAT;
		end
	end

	// ***************************************************************
	// endpoint 2 transmission control
	// ***************************************************************
	always_comb
	begin
		tx_ctr_next = tx_ctr_reg;
		tx_tog_next = tx_tog_reg;
		tx_stat_next = tx_stat_reg;
		// RL12 software clears by writing zero
		if (wr_ep2_tx)
			tx_ctr_next = tx_ctr_reg && wd[BIT_CTR];
		// RL13 software force of the toggle
		if (wr_ep2_tx)
			tx_tog_next = wd[BIT_TOG];
		// RL10 protected in upload mode
		if (wr_ep2_tx && !ul_mode)
			tx_stat_next = wd[BIT_STAT_HI:BIT_STAT_LO];
		// RL13 flip on host ACK
		if (ep2_in)
			tx_tog_next = !tx_tog_reg;
		// RL12 hardware set
		if (tx_sw)
			tx_ctr_next = 1'b1;
		// RL15 force NAK after transfer
		if (ep2_in)
			tx_stat_next = STAT_NAK;
		// RL4 revalidate when the next block is there
		if (tx_revalid)
			tx_stat_next = STAT_VALID;
		// RL11 bus reset clears bits 3:0
		if (bus_reset)
		begin
			tx_ctr_next = RST_BIT;
			tx_tog_next = RST_BIT;
			tx_stat_next = RST_STAT;
		end
	end

	assign rx_wait_next = (rx_wait_reg && !rx_revalid && dl_mode) || rx_hw;
	assign tx_wait_next = (tx_wait_reg && !tx_revalid && ul_mode) || tx_hw;
	assign evt_next = rx_sw || tx_sw;
	assign hw_pkt_next = rx_hw || tx_hw;

	always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			mode_reg <= RST_MODE;
			rx_ctr_reg <= RST_BIT;
			rx_tog_reg <= RST_BIT;
			rx_stat_reg <= RST_STAT;
			tx_ctr_reg <= RST_BIT;
			tx_tog_reg <= RST_BIT;
			tx_stat_reg <= RST_STAT;
			rx_wait_reg <= RST_BIT;
			tx_wait_reg <= RST_BIT;
			evt_reg <= RST_BIT;
			hw_pkt_reg <= RST_BIT;
		end
		else
		begin
			mode_reg <= mode_next;
			rx_ctr_reg <= rx_ctr_next;
			rx_tog_reg <= rx_tog_next;
			rx_stat_reg <= rx_stat_next;
			tx_ctr_reg <= tx_ctr_next;
			tx_tog_reg <= tx_tog_next;
			tx_stat_reg <= tx_stat_next;
			rx_wait_reg <= rx_wait_next;
			tx_wait_reg <= tx_wait_next;
			evt_reg <= evt_next;
			hw_pkt_reg <= hw_pkt_next;
		end
	end

	// ***************************************************************
	// software byte counts and maximum packet sizes
	// ***************************************************************
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			force_bus_reset_reg <= RST_BIT;
			ep0_tx_reg <= RST_CNT01;
			ep1_tx_reg <= RST_CNT01;
			ep2_tx_reg <= RST_CNT2;
			rx_max_reg <= RST_CNT2;
			tx_max_reg <= RST_CNT2;
		end
		else
		begin
			if (wr_ctrl)
				force_bus_reset_reg <= wd[BIT_FORCE_BUS_RESET];
			if (wr_ep0_tx)
				ep0_tx_reg <= wd[CNT01_W-1:0];
			if (wr_ep1_tx)
				ep1_tx_reg <= wd[CNT01_W-1:0];
			if (wr_ep2_txc)
				ep2_tx_reg <= wd[CNT2_W-1:0];
			if (wr_ep2_rxc)
				rx_max_reg <= wd[CNT2_W-1:0];
			if (wr_ep2_txc)
				tx_max_reg <= wd[CNT2_W-1:0];
		end
	end

	// ***************************************************************
	// reception counters
	// ***************************************************************
	// RL16 endpoint 0 count down
	usbebc_rx_counter #(.W(CNT01_W)) u_ep0_rx
	(
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.load_i(wr_ep0_rx),
		.load_val_i(wd[CNT01_W-1:0]),
		.dec_i(ep0_dec),
		.dec_amt_i(XACT_LEN_I),
		.cnt_o(ep0_rx_cnt)
	);

	// RL16 endpoint 1 count down
	usbebc_rx_counter #(.W(CNT01_W)) u_ep1_rx
	(
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.load_i(wr_ep1_rx),
		.load_val_i(wd[CNT01_W-1:0]),
		.dec_i(ep1_dec),
		.dec_amt_i(XACT_LEN_I),
		.cnt_o(ep1_rx_cnt)
	);

	// RL17 endpoint 2 count down, reloaded with the maximum on revalidate
	usbebc_rx_counter #(.W(CNT2_W)) u_ep2_rx
	(
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.load_i(wr_ep2_rxc || rx_revalid),
		.load_val_i(wr_ep2_rxc ? wd[CNT2_W-1:0] : rx_max_reg),
		.dec_i(ep2_out),
		.dec_amt_i(XACT_LEN_I),
		.cnt_o(ep2_rx_cnt)
	);

	// ***************************************************************
	// token handshake selection
	// ***************************************************************
	logic rx_acc;
	logic rx_stl;
	logic rx_nak;
	logic tx_acc;
	logic tx_stl;
	logic tx_nak;

	// RL7 reception status decode
	usbebc_hs_dec u_rx_dec
	(
		.stat_i(rx_stat_reg),
		.token_i(EP2_TOKEN_I && !EP2_TOKEN_IN_I),
		.accept_o(rx_acc),
		.stall_o(rx_stl),
		.nak_o(rx_nak)
	);

	// RL14 transmission status decode
	usbebc_hs_dec u_tx_dec
	(
		.stat_i(tx_stat_reg),
		.token_i(EP2_TOKEN_I && EP2_TOKEN_IN_I),
		.accept_o(tx_acc),
		.stall_o(tx_stl),
		.nak_o(tx_nak)
	);

	assign EP2_ACCEPT_O = rx_acc || tx_acc;
	assign EP2_STALL_O = rx_stl || tx_stl;
	assign EP2_NAK_O = rx_nak || tx_nak;

	// ***************************************************************
	// read mux
	// ***************************************************************
	logic [7:0] rd_ep2_rx;
	logic [7:0] rd_ep2_tx;
	logic [7:0] rd_byte;

	// RL19 bits five and four read zero
	assign rd_ep2_rx = {mode_reg, 2'h0, rx_ctr_reg, rx_tog_reg, rx_stat_reg};
	assign rd_ep2_tx = {4'h0, tx_ctr_reg, tx_tog_reg, tx_stat_reg};
	assign rd_byte =
		(idx == IDX_CTRL) ? {7'h00, force_bus_reset_reg} :
		(idx == IDX_EP0_RX_CNT) ? {3'h0, ep0_rx_cnt} :
		(idx == IDX_EP0_TX_CNT) ? {3'h0, ep0_tx_reg} :
		(idx == IDX_EP1_RX_CNT) ? {3'h0, ep1_rx_cnt} :
		(idx == IDX_EP1_TX_CNT) ? {3'h0, ep1_tx_reg} :
		(idx == IDX_EP2_RX_CTRL) ? rd_ep2_rx :
		(idx == IDX_EP2_RX_CNT) ? {1'h0, ep2_rx_cnt} :
		(idx == IDX_EP2_TX_CTRL) ? rd_ep2_tx :
		(idx == IDX_EP2_TX_CNT) ? {1'h0, ep2_tx_reg} : 8'h00;
	assign dat_next = (bus_req && !WE_I) ? {24'h000000, rd_byte} : dat_reg;

	always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			ack_reg <= RST_BIT;
			dat_reg <= RST_DATA;
		end
		else
		begin
			ack_reg <= bus_req;
			dat_reg <= dat_next;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign ACK_O = ack_reg;
	assign DAT_O = dat_reg;
	assign TRANSFER_OK_EVENT_O = evt_reg;
	assign COPROC_PKT_O = hw_pkt_reg;
	// RL18 endpoint 0/1 send counts
	assign EP0_TX_BYTE_COUNT_O = ep0_tx_reg;
	assign EP1_TX_BYTE_COUNT_O = ep1_tx_reg;
	// RL21 endpoint 2 send count
	assign EP2_TX_BYTE_COUNT_O = ep2_tx_reg;
	assign EP0_RX_BYTE_COUNT_O = ep0_rx_cnt;
	assign EP1_RX_BYTE_COUNT_O = ep1_rx_cnt;
	assign EP2_RX_BYTE_COUNT_O = ep2_rx_cnt;
	assign EP2_RX_PID_TOGGLE_O = rx_tog_reg;
	assign EP2_TX_PID_TOGGLE_O = tx_tog_reg;
	assign EP2_TRANSFER_MODE_O = mode_reg;
	assign FORCE_BUS_RESET_O = force_bus_reset_reg;

endmodule

// ==== include/usbebc_pkg.sv ====
package usbebc_pkg;

	// ***************************************************************
	// register word indices (byte address = index * 4)
	// ***************************************************************
	localparam logic [5:0] IDX_CTRL = 6'h32;
	localparam logic [5:0] IDX_EP0_RX_CNT = 6'h36;
	localparam logic [5:0] IDX_EP0_TX_CNT = 6'h37;
	localparam logic [5:0] IDX_EP1_RX_CNT = 6'h39;
	localparam logic [5:0] IDX_EP1_TX_CNT = 6'h3B;
	localparam logic [5:0] IDX_EP2_RX_CTRL = 6'h3C;
	localparam logic [5:0] IDX_EP2_RX_CNT = 6'h3D;
	localparam logic [5:0] IDX_EP2_TX_CTRL = 6'h3E;
	localparam logic [5:0] IDX_EP2_TX_CNT = 6'h3F;

	// ***************************************************************
	// field positions and widths
	// ***************************************************************
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_CTR = 3;
	localparam int BIT_TOG = 2;
	localparam int BIT_STAT_HI = 1;
	localparam int BIT_STAT_LO = 0;
	localparam int BIT_FORCE_BUS_RESET = 0;
	localparam int CNT01_W = 5;
	localparam int CNT2_W = 7;
	localparam int LEN_W = 7;

	// ***************************************************************
	// encodings
	// ***************************************************************
	localparam logic [1:0] STAT_DISABLED = 2'h0;
	localparam logic [1:0] STAT_STALL = 2'h1;
	localparam logic [1:0] STAT_NAK = 2'h2;
	localparam logic [1:0] STAT_VALID = 2'h3;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_UPLOAD = 2'h1;
	localparam logic [1:0] MODE_DOWNLOAD = 2'h2;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [1:0] RST_STAT = 2'h0;
	localparam logic RST_BIT = 1'h0;
	localparam logic [CNT01_W-1:0] RST_CNT01 = 5'h00;
	localparam logic [CNT2_W-1:0] RST_CNT2 = 7'h00;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;

endpackage

// ==== design/usbebc_hs_dec.sv ====
`timescale 1ns/100ps

// ***************************************************************
// handshake decode of a two-bit endpoint status
// ***************************************************************
module usbebc_hs_dec
	import usbebc_pkg::*;
(
	input wire logic [1:0] stat_i,
	input wire logic token_i,
	output logic accept_o,
	output logic stall_o,
	output logic nak_o
);
	import usbebc_pkg::*;

	// disabled answers nothing: the token is ignored
	assign accept_o = token_i && (stat_i == STAT_VALID);
	assign stall_o = token_i && (stat_i == STAT_STALL);
	assign nak_o = token_i && (stat_i == STAT_NAK);

endmodule

// ==== design/usbebc_rx_counter.sv ====
`timescale 1ns/100ps

// ***************************************************************
// reception byte counter: software load, hardware decrement
// ***************************************************************
module usbebc_rx_counter
	import usbebc_pkg::*;
#(
	parameter int W = CNT01_W
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic dec_i,
	input wire logic [LEN_W-1:0] dec_amt_i,
	output logic [W-1:0] cnt_o
);
	import usbebc_pkg::*;

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic [W-1:0] amt;

	assign amt = W'(dec_amt_i);
	// a hardware decrement wins over a load in the same cycle
	assign cnt_next = dec_i ? W'(cnt_reg - amt) :
		load_i ? load_val_i : cnt_reg;
	assign cnt_o = cnt_reg;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_reg <= W'(0);
		else
			cnt_reg <= cnt_next;
	end

endmodule

// ==== dv/usbebc_checker.sv ====
`timescale 1ns/100ps
module usbebc_checker
	import usbebc_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic ACK_O,
	input wire logic USB_RST_I,
	input wire logic EP2_ACCEPT_O,
	input wire logic EP2_STALL_O,
	input wire logic EP2_NAK_O,
	input wire logic XACT_DONE_I,
	input wire logic [1:0] XACT_EP_I,
	input wire logic XACT_IN_I,
	input wire logic XACT_PID_I,
	input wire logic [usbebc_pkg::LEN_W-1:0] XACT_LEN_I,
	input wire logic TRANSFER_OK_EVENT_O,
	input wire logic COPROC_PKT_O,
	input wire logic [usbebc_pkg::CNT2_W-1:0] EP2_RX_BYTE_COUNT_O,
	input wire logic EP2_RX_PID_TOGGLE_O,
	input wire logic EP2_TX_PID_TOGGLE_O,
	input wire logic [1:0] EP2_TRANSFER_MODE_O
);
	// ***************************************************************
	// maximum packet sizes as last written by software
	// ***************************************************************
	logic [6:0] rx_max;
	logic [6:0] tx_max;
	wire wr = CYC_I & STB_I & WE_I & ~ACK_O;
	wire [5:0] idx = ADR_I[7:2];
	wire done2 = XACT_DONE_I & (XACT_EP_I == 2'h2);
	wire e2out = done2 & ~XACT_IN_I;
	wire e2in = done2 & XACT_IN_I;
	wire dl = EP2_TRANSFER_MODE_O == MODE_DOWNLOAD;
	wire ul = EP2_TRANSFER_MODE_O == MODE_UPLOAD;
	wire nrm = EP2_TRANSFER_MODE_O == MODE_NORMAL;
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rx_max <= RST_CNT2;
			tx_max <= RST_CNT2;
		end
		else if (wr && idx == IDX_EP2_RX_CNT)
			rx_max <= DAT_I[6:0];
		else if (wr && idx == IDX_EP2_TX_CNT)
			tx_max <= DAT_I[6:0];
	end
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (SYS_RST_I);
	a_hs_one_answer: assert property (
		$onehot0({EP2_ACCEPT_O, EP2_STALL_O, EP2_NAK_O}))
		else $error("several handshakes at once");
	a_dl_full_silent: assert property (
		dl && e2out && XACT_LEN_I == rx_max |=> COPROC_PKT_O
		&& !TRANSFER_OK_EVENT_O) else $error("full download packet wrong");
	a_dl_short_exit: assert property (
		dl && e2out && XACT_LEN_I < rx_max |=> TRANSFER_OK_EVENT_O
		&& EP2_TRANSFER_MODE_O == MODE_NORMAL) else $error("short packet");
	a_dl_in_event: assert property (
		dl && e2in |=> TRANSFER_OK_EVENT_O && !COPROC_PKT_O)
		else $error("download mode IN without event");
	a_ul_full_silent: assert property (
		ul && e2in && XACT_LEN_I == tx_max |=> COPROC_PKT_O
		&& !TRANSFER_OK_EVENT_O) else $error("full upload packet wrong");
	a_rx_tog_match: assert property (
		nrm && e2out && !wr && !USB_RST_I |=> EP2_RX_PID_TOGGLE_O ==
		($past(EP2_RX_PID_TOGGLE_O) ^ ($past(XACT_PID_I) ==
		$past(EP2_RX_PID_TOGGLE_O)))) else $error("rx toggle wrong");
	a_tx_tog_flip: assert property (
		e2in && !wr && !USB_RST_I |=> $changed(EP2_TX_PID_TOGGLE_O))
		else $error("tx toggle kept after IN");
	a_rx_cnt_dec: assert property (
		nrm && e2out |=> EP2_RX_BYTE_COUNT_O ==
		7'($past(EP2_RX_BYTE_COUNT_O) - $past(XACT_LEN_I)))
		else $error("rx count not decremented");
	a_bus_rst_clr: assert property (
		USB_RST_I && !XACT_DONE_I && !wr |=> !EP2_TX_PID_TOGGLE_O
		&& !EP2_RX_PID_TOGGLE_O) else $error("toggle kept in bus reset");
	c_short: cover property (dl && e2out && XACT_LEN_I < rx_max);
	c_upload: cover property (ul && e2in);
	c_stall: cover property (EP2_STALL_O);
endmodule
bind usbebc_core usbebc_checker i_checker (.*);

// ==== dv/usbebc_host_model.sv ====
`timescale 1ns/100ps
module usbebc_host_model
	import usbebc_pkg::*;
(
	input wire logic clk_i,
	input wire logic accept_i,
	input wire logic stall_i,
	input wire logic nak_i,
	output logic token_o,
	output logic token_in_o,
	output logic done_o,
	output logic [1:0] ep_o,
	output logic in_o,
	output logic pid_o,
	output logic [LEN_W-1:0] len_o
);
	// ***************************************************************
	// host side: tokens and finished transactions
	// ***************************************************************
	initial
	begin
		token_o = 1'b0;
		token_in_o = 1'b0;
		done_o = 1'b0;
		ep_o = 2'h3;
		in_o = 1'b0;
		pid_o = 1'b0;
		len_o = 7'h00;
	end
	task automatic token(input logic dir, output logic [7:0] ans);
		token_o <= 1'b1;
		token_in_o <= dir;
		@(posedge clk_i);
		ans = {5'h00, accept_i, stall_i, nak_i};
		token_o <= 1'b0;
		token_in_o <= ~dir;
	endtask
	// endpoint, PID and length scrambled after the pulse so stale values never pass
	task automatic xact(input logic [1:0] ep, input logic dir,
		input logic pid, input logic [LEN_W-1:0] n);
		ep_o <= ep;
		in_o <= dir;
		pid_o <= pid;
		len_o <= n;
		done_o <= 1'b1;
		@(posedge clk_i);
		done_o <= 1'b0;
		ep_o <= ~ep;
		pid_o <= ~pid;
		len_o <= ~n;
		@(posedge clk_i);
	endtask
endmodule

// ==== dv/usbebc_core_bench.sv ====
`timescale 1ns/100ps
module usbebc_core_bench;
	import usbebc_pkg::*;
	// ***************************************************************
	// stimulus, register access and comparison
	// ***************************************************************
	logic clk, rst, cyc, stb, we, ack, urst, tok, tin, acc, stl, nak;
	logic done, xin, pid, bufr, evt, cpk, fr;
	logic [7:0] adr, v, h;
	logic [3:0] sel;
	logic [31:0] dw, rdat, dr;
	logic [1:0] xep;
	logic [6:0] len, n, tc2;
	logic [4:0] tc0, tc1, rc0, rc1;
	int failures, total_checks, cycles;
	logic [5:0] ridx [7] = '{IDX_EP0_RX_CNT, IDX_EP0_TX_CNT, IDX_EP1_RX_CNT,
		IDX_EP1_TX_CNT, IDX_EP2_RX_CNT, IDX_EP2_TX_CNT, 6'h00};
	logic [7:0] msk [7] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h7F, 8'h7F, 8'h00};
	logic [7:0] wv [7];
	usbebc_core i_dut (
		.CLOCK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dw), .DAT_O(rdat), .ACK_O(ack),
		.USB_RST_I(urst), .EP2_TOKEN_I(tok), .EP2_TOKEN_IN_I(tin),
		.EP2_ACCEPT_O(acc), .EP2_STALL_O(stl), .EP2_NAK_O(nak),
		.XACT_DONE_I(done), .XACT_EP_I(xep), .XACT_IN_I(xin), .XACT_PID_I(pid),
		.XACT_LEN_I(len), .BUF_READY_I(bufr), .TRANSFER_OK_EVENT_O(evt),
		.COPROC_PKT_O(cpk), .EP0_TX_BYTE_COUNT_O(tc0),
		.EP1_TX_BYTE_COUNT_O(tc1),
		.EP2_TX_BYTE_COUNT_O(tc2), .EP0_RX_BYTE_COUNT_O(rc0),
		.EP1_RX_BYTE_COUNT_O(rc1), .EP2_RX_BYTE_COUNT_O(),
		.EP2_RX_PID_TOGGLE_O(), .EP2_TX_PID_TOGGLE_O(),
		.EP2_TRANSFER_MODE_O(), .FORCE_BUS_RESET_O(fr)
	);
	usbebc_host_model i_host (.clk_i(clk), .accept_i(acc), .stall_i(stl),
		.nak_i(nak), .token_o(tok), .token_in_o(tin), .done_o(done),
		.ep_o(xep), .in_o(xin), .pid_o(pid), .len_o(len));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'h0};
		dw <= {24'h000000, d};
		@(posedge clk);
		while (ack !== 1'b1 && k < 20)
		begin
			k++;
			@(posedge clk);
		end
		if (k == 20)
			failures++;
		dr = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] m, e);
		wb(1'b0, a, 8'h00);
		cmp(dr[7:0] & m, e);
	endtask
	function automatic logic [7:0] hs(input logic [1:0] s);
		return (s == STAT_VALID) ? 8'h04 : (s == STAT_STALL) ? 8'h02 :
			(s == STAT_NAK) ? 8'h01 : 8'h00;
	endfunction
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			complete_run();
		end
	end
	initial
	begin
		{cyc, stb, we, urst, bufr, adr, dw} = '0;
		sel = 4'hF;
		rst = 1'b1;
		v = 8'($urandom(32'h737C));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rc(ridx[i], 8'hFF, 8'h00);
			wv[i] = 8'($urandom);
			wb(1'b1, ridx[i], wv[i]);
			rc(ridx[i], 8'hFF, wv[i] & msk[i]);
		end
		cmp({3'h0, tc0}, wv[1] & 8'h1F);
		cmp({3'h0, tc1}, wv[3] & 8'h1F);
		cmp({1'h0, tc2}, wv[5] & 8'h7F);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h3F);
		rc(IDX_EP2_RX_CTRL, 8'hFF, 8'h07);
		for (int s = 0; s < 4; s++)
		begin
			wb(1'b1, IDX_EP2_RX_CTRL, 8'(s));
			wb(1'b1, IDX_EP2_TX_CTRL, 8'(s));
			i_host.token(1'b0, h);
			cmp(h, hs(2'(s)));
			i_host.token(1'b1, h);
			cmp(h, hs(2'(s)));
		end
		n = 7'(1 + $urandom % 63);
		wb(1'b1, IDX_EP2_RX_CNT, 8'h40);
		i_host.xact(2'h2, 1'b0, 1'b0, n);
		cmp({6'h00, evt, cpk}, 8'h02);
		rc(IDX_EP2_RX_CTRL, 8'hFF, 8'h0E);
		rc(IDX_EP2_RX_CNT, 8'hFF, 8'h40 - 8'(n));
		i_host.xact(2'h2, 1'b0, 1'b0, 7'h05);
		rc(IDX_EP2_RX_CTRL, 8'hFF, 8'h0E);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h06);
		rc(IDX_EP2_RX_CTRL, 8'hFF, 8'h06);
		i_host.xact(2'h2, 1'b1, 1'b0, 7'h08);
		cmp({6'h00, evt, cpk}, 8'h02);
		rc(IDX_EP2_TX_CTRL, 8'hFF, 8'h0E);
		wb(1'b1, IDX_EP2_TX_CTRL, 8'h02);
		wb(1'b1, IDX_EP2_TX_CNT, 8'h40);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h40);
		wb(1'b1, IDX_EP2_TX_CTRL, 8'h03);
		rc(IDX_EP2_TX_CTRL, 8'hFF, 8'h02);
		i_host.xact(2'h2, 1'b1, 1'b0, 7'h40);
		cmp({6'h00, evt, cpk}, 8'h01);
		bufr <= 1'b1;
		repeat (2) @(posedge clk);
		bufr <= 1'b0;
		rc(IDX_EP2_TX_CTRL, 8'h0B, 8'h03);
		i_host.xact(2'h2, 1'b1, 1'b1, 7'h0A);
		cmp({6'h00, evt, cpk}, 8'h02);
		rc(IDX_EP2_RX_CTRL, 8'hC0, 8'h00);
		wb(1'b1, IDX_EP2_RX_CNT, 8'h40);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h03);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h83);
		wb(1'b1, IDX_EP2_RX_CTRL, 8'h81);
		rc(IDX_EP2_RX_CTRL, 8'hC3, 8'h83);
		i_host.xact(2'h2, 1'b1, 1'b0, 7'h04);
		cmp({6'h00, evt, cpk}, 8'h02);
		i_host.xact(2'h2, 1'b0, 1'b0, 7'h40);
		cmp({6'h00, evt, cpk}, 8'h01);
		rc(IDX_EP2_RX_CTRL, 8'h0B, 8'h02);
		bufr <= 1'b1;
		repeat (2) @(posedge clk);
		bufr <= 1'b0;
		rc(IDX_EP2_RX_CTRL, 8'h03, 8'h03);
		i_host.xact(2'h2, 1'b0, 1'b1, 7'h05);
		cmp({6'h00, evt, cpk}, 8'h02);
		rc(IDX_EP2_RX_CTRL, 8'hCB, 8'h0A);
		wb(1'b1, IDX_EP2_TX_CTRL, 8'h07);
		urst <= 1'b1;
		@(posedge clk);
		urst <= 1'b0;
		rc(IDX_EP2_TX_CTRL, 8'h07, 8'h00);
		wb(1'b1, IDX_EP2_TX_CTRL, 8'h07);
		wb(1'b1, IDX_CTRL, 8'h01);
		cmp({7'h00, fr}, 8'h01);
		wb(1'b1, IDX_CTRL, 8'h00);
		rc(IDX_EP2_TX_CTRL, 8'h07, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			v = 8'($urandom % 32);
			n = 7'($urandom % (v + 1));
			wb(1'b1, i[0] ? IDX_EP1_RX_CNT : IDX_EP0_RX_CNT, v);
			i_host.xact({1'b0, i[0]}, 1'b0, 1'($urandom), n);
			cmp({3'h0, i[0] ? rc1 : rc0}, v - 8'(n));
		end
		complete_run();
	end
endmodule
